// ---- hw/reset_pin_filter.sv ----
// Reset pin glitch filter on bus clock or low-power clock
`timescale 1ns/1ps
module reset_pin_filter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Filter carrier
  pin_filter_if.filt pf
);
  // ****************************************
  // Filter counter
  // ****************************************
  logic [rcu_pkg::FILT_WIDTH_W-1:0] cnt_q; // Persistence count
  logic filt_q; // Accepted level
  logic use_lpo; // Counting low-power ticks
  logic bypass; // No filtering at all
  logic step; // Counter advances this cycle
  logic [rcu_pkg::FILT_WIDTH_W-1:0] limit; // Count needed to accept

  // Mode decode: stop mode only knows the low-power filter
  always_comb
  begin
    use_lpo = pf.stop_mode || (pf.sel == rcu_pkg::FILT_LPO);
    bypass = pf.stop_mode ? !pf.stop_en : (pf.sel == rcu_pkg::FILT_OFF);
    step = use_lpo ? pf.lpo_tick : 1'b1;
    if (use_lpo)
    begin
      limit = rcu_pkg::FILT_WIDTH_W'(rcu_pkg::LPO_FILT_TICKS);
    end
    else
    begin
      // Width zero still needs one clock
      limit = (pf.width == '0) ? 5'h01 : pf.width;
    end
  end

  // Level must persist for the limit before it is taken
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cnt_q <= '0;
      filt_q <= 1'b1;
    end
    else if (bypass || (pf.raw_n == filt_q))
    begin
      cnt_q <= '0; // [RULE7] [RULE8]
      filt_q <= pf.raw_n;
    end
    else if (step)
    begin
      if (cnt_q + 5'h01 >= limit)
      begin
        cnt_q <= '0; // [RULE9]
        filt_q <= pf.raw_n;
      end
      else
      begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  assign pf.filt_n = filt_q;
endmodule

// ---- hw/reset_source_control_unit.sv ----
// Reset source control unit with AXI4-Lite register access
//
// Notes on behaviour
// [RULE1] Version register: major, minor, feature number.
// [RULE2] Read-only map of implemented reset sources.
// [RULE3] Status map of the last reset's sources.
// [RULE4] Sticky source flags accumulate until software clears.
// [RULE5] Mask write clears only selected sticky flags.
// [RULE6] Thirteen distinct reset source flags.
// [RULE7] Run/wait pin filter: off, bus, low-power.
// [RULE8] Separate pin filter enable in stop mode.
// [RULE9] Bus filter width set by count field.
// [RULE10] Serial programming select pin status readable.
// [RULE11] Boot source recorded with four encodings.
// [RULE12] Software clears the recorded boot source.
// [RULE13] Force setting boots ROM on later resets.
// [RULE14] Reset interrupt first, system reset after delay.
// [RULE15] Delay of 8, 32, 128, 512 cycles.
// [RULE16] Per-source interrupt enables plus global enable.
// [RULE17] Low-power clock runs at 1 kHz.
// [RULE18] Status captured at reset, kept afterwards.
`timescale 1ns/1ps
module reset_source_control_unit #(
  parameter logic [7:0] VER_MAJOR = 8'h01, // Arbitrary value
  parameter logic [7:0] VER_MINOR = 8'h00, // Arbitrary value
  parameter logic [15:0] VER_FEATURE = 16'h0003, // Arbitrary value
  parameter logic [12:0] SRC_IMPL = 13'h1FFF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // AXI4-Lite write channels
  input wire logic [7:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  // AXI4-Lite read channels
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // Reset requests from on-chip sources
  input wire logic [12:0] src_req_i,
  input wire logic core1_req_i,
  // Pins and chip state
  input wire logic lpo_clk_i,
  input wire logic reset_pin_n_i,
  input wire logic serial_prog_mode_select_n_i,
  input wire logic boot_config_pin0_i,
  input wire logic [7:0] flash_option_byte_i,
  input wire logic stop_mode_i,
  // Reset network
  output logic reset_irq_o,
  output logic sys_reset_o,
  output logic force_boot_rom_o
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] meta_q; // First stage, read only by second
  logic [3:0] sync_q; // Second stage
  logic lpo_prev_q; // Previous low-power level
  logic lpo_tick; // Rising edge of low-power clock

  // Two flops on every pin and on the 1 kHz clock
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      meta_q <= 4'h3;
      sync_q <= 4'h3;
      lpo_prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= {boot_config_pin0_i, lpo_clk_i, serial_prog_mode_select_n_i,
                 reset_pin_n_i};
      sync_q <= meta_q;
      lpo_prev_q <= sync_q[2];
    end
  end

  assign lpo_tick = sync_q[2] && !lpo_prev_q; // [RULE17]

  // ****************************************
  // Pin filter
  // ****************************************
  pin_filter_if pf ();
  logic [1:0] filt_sel_q; // Run/wait filter selection
  logic filt_stop_q; // Stop mode filter enable
  logic [rcu_pkg::FILT_WIDTH_W-1:0] filt_width_q; // Bus filter width

  assign pf.raw_n = sync_q[0];
  assign pf.lpo_tick = lpo_tick;
  assign pf.stop_mode = stop_mode_i;
  assign pf.sel = filt_sel_q; // [RULE7]
  assign pf.stop_en = filt_stop_q; // [RULE8]
  assign pf.width = filt_width_q; // [RULE9]

  reset_pin_filter u_filter (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pf(pf)
  );

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic aw_full_q; // Write address held
  logic w_full_q; // Write data held
  logic [7:0] awaddr_q; // Held write address
  logic [31:0] wdata_q; // Held write data
  logic [3:0] wstrb_q; // Held byte enables
  logic bvalid_q; // Write response pending
  logic bad_w_q; // Write response is an error
  logic rvalid_q; // Read data pending
  logic [31:0] rdata_q; // Read data
  logic bad_r_q; // Read response is an error
  logic wr_go; // Write performed this cycle
  logic [31:0] wmask; // Bits enabled by strobes
  logic [31:0] wval; // Strobed write data
  logic wr_hit; // Write address mapped

  assign s_awready_o = !aw_full_q;
  assign s_wready_o = !w_full_q;
  assign s_bvalid_o = bvalid_q;
  assign s_bresp_o = bad_w_q ? 2'h2 : 2'h0;
  assign s_arready_o = !rvalid_q;
  assign s_rvalid_o = rvalid_q;
  assign s_rdata_o = rdata_q;
  assign s_rresp_o = bad_r_q ? 2'h2 : 2'h0;
  assign wr_go = aw_full_q && w_full_q && !bvalid_q;

  // Byte lanes to a bit mask
  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      wmask[b*8 +: 8] = {8{wstrb_q[b]}};
    end
    wval = wdata_q & wmask;
    wr_hit = awaddr_q inside {rcu_pkg::OFS_VERSION, rcu_pkg::OFS_PARAM,
      rcu_pkg::OFS_STATUS, rcu_pkg::OFS_STICKY, rcu_pkg::OFS_FILT_CTRL,
      rcu_pkg::OFS_FILT_WIDTH, rcu_pkg::OFS_MODE, rcu_pkg::OFS_FORCE,
      rcu_pkg::OFS_INT_CTRL};
  end

  // Address and data taken in either order, answered together
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bad_w_q <= 1'b0;
    end
    else
    begin
      if (s_awvalid_i && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        awaddr_q <= {s_awaddr_i[7:2], 2'h0};
      end
      if (s_wvalid_i && !w_full_q)
      begin
        w_full_q <= 1'b1;
        wdata_q <= s_wdata_i;
        wstrb_q <= s_wstrb_i;
      end
      if (wr_go)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bad_w_q <= !wr_hit;
      end
      else if (bvalid_q && s_bready_i)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic [1:0] force_q; // Force boot from ROM
  logic [rcu_pkg::IE_W-1:0] ie_q; // Interrupt enables and delay

  // Software-written configuration
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      filt_sel_q <= rcu_pkg::FILT_SEL_RST;
      filt_stop_q <= 1'b0;
      filt_width_q <= rcu_pkg::FILT_WIDTH_RST;
      force_q <= rcu_pkg::FORCE_RST;
      ie_q <= rcu_pkg::IE_RST;
    end
    else if (wr_go)
    begin
      unique case (awaddr_q)
        rcu_pkg::OFS_FILT_CTRL:
        begin
          filt_sel_q <= (wval[1:0] & wmask[1:0]) | (filt_sel_q & ~wmask[1:0]);
          if (wmask[rcu_pkg::FILT_STOP_BIT])
          begin
            filt_stop_q <= wval[rcu_pkg::FILT_STOP_BIT];
          end
        end
        rcu_pkg::OFS_FILT_WIDTH:
        begin
          if (wstrb_q[0])
          begin
            filt_width_q <= wval[rcu_pkg::FILT_WIDTH_W-1:0];
          end
        end
        rcu_pkg::OFS_FORCE:
        begin
          if (wstrb_q[0])
          begin
            force_q <= wval[rcu_pkg::FORCE_LSB +: 2]; // [RULE13]
          end
        end
        rcu_pkg::OFS_INT_CTRL:
        begin
          // [RULE15] [RULE16]
          ie_q <= (wval[rcu_pkg::IE_W-1:0] & wmask[rcu_pkg::IE_W-1:0])
                  | (ie_q & ~wmask[rcu_pkg::IE_W-1:0]);
        end
        default:
        begin
          // Other offsets hold no writable control
        end
      endcase
    end
  end

  assign force_boot_rom_o = (force_q != 2'h0); // [RULE13]

  // ****************************************
  // Reset sequencer
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_ASSERT} seq_st_t;
  seq_st_t st_q; // Sequencer state
  logic [12:0] pend_q; // Sources seen in this sequence
  logic [9:0] dly_cnt_q; // Low-power cycles waited
  logic [4:0] hold_q; // System reset clocks elapsed
  logic [rcu_pkg::NEVT-1:0] evt; // All reset events
  logic [rcu_pkg::NEVT-1:0] irq_ok; // Events that may be delayed
  logic [12:0] cap_vec; // Sources latched at capture
  logic [9:0] dly_limit; // Selected delay
  logic cap; // Capture into status this cycle
  logic urgent; // Event with no interrupt path

  always_comb
  begin
    evt = {core1_req_i, src_req_i};
    evt[rcu_pkg::SRC_PIN] = !pf.filt_n; // [RULE6]
    irq_ok = '0;
    irq_ok[rcu_pkg::SRC_LOC] = ie_q[rcu_pkg::IE_LOC]; // [RULE16]
    irq_ok[rcu_pkg::SRC_LOL] = ie_q[rcu_pkg::IE_LOL];
    irq_ok[rcu_pkg::SRC_WATCHDOG_TIMER] = ie_q[rcu_pkg::IE_WATCHDOG_TIMER];
    irq_ok[rcu_pkg::SRC_PIN] = ie_q[rcu_pkg::IE_PIN];
    irq_ok[rcu_pkg::SRC_LOCKUP] = ie_q[rcu_pkg::IE_LOCKUP];
    irq_ok[rcu_pkg::SRC_SW] = ie_q[rcu_pkg::IE_SW];
    irq_ok[rcu_pkg::SRC_STOP_ACK_ERROR] = ie_q[rcu_pkg::IE_STOP_ACK_ERROR];
    irq_ok[rcu_pkg::EVT_CORE1] = ie_q[rcu_pkg::IE_CORE1];
    irq_ok = irq_ok & {rcu_pkg::NEVT{ie_q[rcu_pkg::IE_GLOBAL]}};
    urgent = |(evt & ~irq_ok);
    unique case (ie_q[rcu_pkg::IE_DELAY_LSB +: 2]) // [RULE15]
      2'h0: dly_limit = rcu_pkg::DLY_8;
      2'h1: dly_limit = rcu_pkg::DLY_32;
      2'h2: dly_limit = rcu_pkg::DLY_128;
      2'h3: dly_limit = rcu_pkg::DLY_512;
    endcase
    cap_vec = pend_q | evt[12:0];
    cap = 1'b0;
    if (st_q == ST_IDLE)
    begin
      cap = (|evt) && urgent;
      cap_vec = evt[12:0];
    end
    else if (st_q == ST_DELAY)
    begin
      cap = urgent || (dly_cnt_q >= dly_limit);
    end
  end

  // Interrupt first when every event is enabled, then the system reset pulse
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st_q <= ST_IDLE;
      pend_q <= '0;
      dly_cnt_q <= '0;
      hold_q <= '0;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
        begin
          pend_q <= evt[12:0];
          dly_cnt_q <= '0;
          hold_q <= '0;
          if (cap)
          begin
            st_q <= ST_ASSERT;
          end
          else if (|evt)
          begin
            st_q <= ST_DELAY; // [RULE14]
          end
        end
        ST_DELAY:
        begin
          pend_q <= cap_vec;
          if (cap)
          begin
            st_q <= ST_ASSERT; // [RULE14]
          end
          else if (lpo_tick)
          begin
            dly_cnt_q <= dly_cnt_q + 10'h001;
          end
        end
        ST_ASSERT:
        begin
          hold_q <= hold_q + 5'h01;
          if (hold_q == 5'(rcu_pkg::RST_HOLD_CYC - 1))
          begin
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign reset_irq_o = (st_q == ST_DELAY); // [RULE14]
  assign sys_reset_o = (st_q == ST_ASSERT);

  // ****************************************
  // Captured status
  // ****************************************
  logic [12:0] status_q; // Sources of the last reset
  logic [12:0] sticky_q; // Accumulated sources
  logic [1:0] boot_q; // Boot source of the last reset
  logic sticky_wr; // Sticky clear write this cycle
  logic boot_wr; // Boot source clear write this cycle

  assign sticky_wr = wr_go && (awaddr_q == rcu_pkg::OFS_STICKY);
  assign boot_wr = wr_go && (awaddr_q == rcu_pkg::OFS_MODE);

  // Kept across the system reset; the unit reset clears them, software writes clear sticky and boot bits
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      status_q <= '0;
      sticky_q <= '0;
      boot_q <= 2'h0;
    end
    else
    begin
      if (cap)
      begin
        status_q <= cap_vec; // [RULE3] [RULE18]
      end
      // New capture wins over a clear in the same cycle
      sticky_q <= (sticky_q & ~(sticky_wr ? wmask[12:0] & wval[12:0] : '0))
                  | (cap ? cap_vec : '0); // [RULE4] [RULE5]
      if (cap)
      begin
        // Bit 0 boot pin or forced, bit 1 option bit 7
        boot_q <= {flash_option_byte_i[7], sync_q[3]}
                  | (force_boot_rom_o ? 2'h1 : 2'h0); // [RULE11] [RULE13]
      end
      else if (boot_wr && wmask[rcu_pkg::MODE_BOOT_LSB])
      begin
        boot_q <= boot_q & ~wval[rcu_pkg::MODE_BOOT_LSB +: 2]; // [RULE12]
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [31:0] rd_val; // Selected read value
  logic rd_hit; // Read address mapped

  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case ({s_araddr_i[7:2], 2'h0})
      rcu_pkg::OFS_VERSION: rd_val = {VER_MAJOR, VER_MINOR, VER_FEATURE};
      rcu_pkg::OFS_PARAM: rd_val = {19'h0, SRC_IMPL}; // [RULE2]
      rcu_pkg::OFS_STATUS: rd_val = {19'h0, status_q}; // [RULE3]
      rcu_pkg::OFS_STICKY: rd_val = {19'h0, sticky_q}; // [RULE4]
      rcu_pkg::OFS_FILT_CTRL: rd_val = {29'h0, filt_stop_q, filt_sel_q};
      rcu_pkg::OFS_FILT_WIDTH: rd_val = {27'h0, filt_width_q};
      rcu_pkg::OFS_MODE: rd_val = {29'h0, boot_q, !sync_q[1]}; // [RULE10]
      rcu_pkg::OFS_FORCE: rd_val = {29'h0, force_q, 1'b0};
      rcu_pkg::OFS_INT_CTRL: rd_val = {21'h0, ie_q};
      default: rd_hit = 1'b0;
    endcase
  end

  // One cycle to answer, held until taken
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      bad_r_q <= 1'b0;
    end
    else if (s_arvalid_i && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val; // [RULE1]
      bad_r_q <= !rd_hit;
    end
    else if (rvalid_q && s_rready_i)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  sticky_clear_a: assert property ((sticky_wr && !cap) |=> // [RULE5]
    ((sticky_q & $past(wmask[12:0] & wval[12:0])) == '0))
    else $error("sticky flags not cleared by mask");
  sticky_keep_a: assert property (!sticky_wr |=> // [RULE4]
    ((sticky_q & $past(sticky_q)) == $past(sticky_q)))
    else $error("sticky flag lost without clear");
  irq_first_a: assert property ( // [RULE14]
    (st_q == ST_IDLE && !cap && |evt) |=> (reset_irq_o && !sys_reset_o))
    else $error("system reset before interrupt");
  delay_max_a: assert property ((st_q == ST_DELAY) |-> // [RULE15]
    (dly_cnt_q <= dly_limit))
    else $error("reset delay overran");
  status_cap_a: assert property (cap |=> // [RULE18]
    (status_q == $past(cap_vec) && sys_reset_o))
    else $error("reset status not captured");
  status_hold_a: assert property (!cap |=> $stable(status_q)) // [RULE3]
    else $error("reset status changed without reset");
  rst_pulse_a: assert property ($rose(sys_reset_o) |-> // [RULE14]
    sys_reset_o[*8])
    else $error("system reset pulse too short");
  urgent_now_a: assert property ((st_q == ST_DELAY && urgent) |=> // [RULE16]
    sys_reset_o)
    else $error("non-enabled source was delayed");
  boot_clr_a: assert property ((boot_wr && !cap && wmask[1] && // [RULE12]
    wval[2:1] == 2'h3) |=> (boot_q == 2'h0))
    else $error("boot source not cleared");

  delayed_c: cover property (reset_irq_o ##[1:1000] sys_reset_o);
  direct_c: cover property (!reset_irq_o ##1 $rose(sys_reset_o));
  sticky_c: cover property (sticky_wr && cap);
  read_c: cover property (rvalid_q && s_rready_i);
endmodule

// ---- shared/pin_filter_if.sv ----
// Carrier between the unit and its reset pin filter
`timescale 1ns/1ps
interface pin_filter_if;
  logic raw_n; // Synchronised pin level
  logic lpo_tick; // One pulse per low-power clock cycle
  logic stop_mode; // Chip in stop mode
  logic [1:0] sel; // Run/wait filter selection
  logic stop_en; // Filter enable in stop mode
  logic [rcu_pkg::FILT_WIDTH_W-1:0] width; // Bus clock filter width
  logic filt_n; // Accepted pin level
  modport filt (
    input raw_n, lpo_tick, stop_mode, sel, stop_en, width,
    output filt_n
  );
  modport ctrl (
    output raw_n, lpo_tick, stop_mode, sel, stop_en, width,
    input filt_n
  );
endinterface

// ---- shared/rcu_pkg.sv ----
// Constants, offsets, field layouts and reset values of the reset control unit
package rcu_pkg;
  // ****************************************
  // Reset source bit positions
  // ****************************************
  localparam int NSRC = 13;
  localparam int SRC_WAKEUP = 0;
  localparam int SRC_LVD = 1;
  localparam int SRC_LOC = 2;
  localparam int SRC_LOL = 3;
  localparam int SRC_WATCHDOG_TIMER = 4;
  localparam int SRC_PIN = 5;
  localparam int SRC_POR = 6;
  localparam int SRC_SCAN = 7;
  localparam int SRC_LOCKUP = 8;
  localparam int SRC_SW = 9;
  localparam int SRC_MAILBOX = 10;
  localparam int SRC_SPROG = 11;
  localparam int SRC_STOP_ACK_ERROR = 12;
  // Index of the second-core request in the event vector
  localparam int EVT_CORE1 = 13;
  localparam int NEVT = 14;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_VERSION = 8'h00;
  localparam logic [7:0] OFS_PARAM = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_STICKY = 8'h0C;
  localparam logic [7:0] OFS_FILT_CTRL = 8'h10;
  localparam logic [7:0] OFS_FILT_WIDTH = 8'h14;
  localparam logic [7:0] OFS_MODE = 8'h18;
  localparam logic [7:0] OFS_FORCE = 8'h1C;
  localparam logic [7:0] OFS_INT_CTRL = 8'h20;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int VER_MAJOR_LSB = 24;
  localparam int VER_MINOR_LSB = 16;
  localparam int MODE_SPROG_BIT = 0;
  localparam int MODE_BOOT_LSB = 1;
  localparam int FORCE_LSB = 1;
  localparam int FILT_STOP_BIT = 2;
  localparam int FILT_WIDTH_W = 5;
  localparam int IE_DELAY_LSB = 0;
  localparam int IE_LOC = 2;
  localparam int IE_LOL = 3;
  localparam int IE_WATCHDOG_TIMER = 4;
  localparam int IE_PIN = 5;
  localparam int IE_GLOBAL = 6;
  localparam int IE_LOCKUP = 7;
  localparam int IE_SW = 8;
  localparam int IE_STOP_ACK_ERROR = 9;
  localparam int IE_CORE1 = 10;
  localparam int IE_W = 11;

  // ****************************************
  // Reset values and timing counts
  // ****************************************
  localparam logic [1:0] FILT_SEL_RST = 2'h0;
  localparam logic [FILT_WIDTH_W-1:0] FILT_WIDTH_RST = 5'h00;
  localparam logic [IE_W-1:0] IE_RST = 11'h000;
  localparam logic [1:0] FORCE_RST = 2'h0;
  // Low-power clock rate, in hertz
  localparam int LPO_HZ = 1000;
  // Reset delays, in low-power clock cycles
  localparam logic [9:0] DLY_8 = 10'h008;
  localparam logic [9:0] DLY_32 = 10'h020;
  localparam logic [9:0] DLY_128 = 10'h080;
  localparam logic [9:0] DLY_512 = 10'h200;
  // Low-power filter width, in low-power clock cycles
  localparam logic [2:0] LPO_FILT_TICKS = 3'h3;
  // System reset pulse length, in bus clocks
  localparam int RST_HOLD_CYC = 16;

  // Run/wait filter selection
  typedef enum logic [1:0] {
    FILT_OFF = 2'h0,
    FILT_BUS = 2'h1,
    FILT_LPO = 2'h2
  } filt_sel_t;
endpackage

// ---- testbench/rcu_partner.sv ----
// Model of the on-chip reset sources and the low-power clock
`timescale 1ns/1ps
module rcu_partner (
  // Clock and commands
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [12:0] fire_i,
  input wire logic sys_reset_i,
  // Source side
  output logic [12:0] src_req_o,
  output logic lpo_clk_o
);
  // ****************************************
  // Low-power clock, fast stand-in
  // ****************************************
  // Phase unrelated to the bus clock
  initial
  begin
    lpo_clk_o = 1'b0;
    forever #97 lpo_clk_o = ~lpo_clk_o;
  end

  // ****************************************
  // Request levels
  // ****************************************
  // A source holds its request until the system reset clears it
  always_ff @(posedge clk_i)
  begin
    if (srst_i || sys_reset_i)
      src_req_o <= 13'h0000;
    else
      src_req_o <= src_req_o | fire_i;
  end
endmodule

// ---- testbench/reset_source_control_unit_bench.sv ----
// Self-checking bench of the reset source control unit
`timescale 1ns/1ps
module reset_source_control_unit_bench;
  // ****************************************
  // Signals
  // ****************************************
  logic clk_i = 1'b0, srst_i = 1'b1;
  logic [7:0] s_awaddr_i = 8'h00, s_araddr_i = 8'h00;
  logic s_awvalid_i = 1'b0, s_wvalid_i = 1'b0, s_bready_i = 1'b0;
  logic s_arvalid_i = 1'b0, s_rready_i = 1'b0;
  logic [31:0] s_wdata_i = 32'h0, s_rdata_o, rd_d;
  logic [3:0] s_wstrb_i = 4'hF;
  logic [1:0] s_bresp_o, s_rresp_o, rd_r;
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
  logic [12:0] src_req_i, fire = 13'h0000;
  logic pin_n = 1'b1; // Reset pin level, idle high
  logic lpo_clk_i, reset_irq_o, sys_reset_o, force_boot_rom_o;
  int mismatches = 0, samples_checked = 0, n;

  // Bus clock, 25 ns period
  always #12.5 clk_i = ~clk_i;

  // ****************************************
  // Design and partner
  // ****************************************
  reset_source_control_unit i_dut (.clk_i, .srst_i, .s_awaddr_i,
    .s_awvalid_i, .s_awready_o, .s_wdata_i, .s_wstrb_i, .s_wvalid_i,
    .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i,
    .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o,
    .s_rready_i, .src_req_i, .core1_req_i(1'b0), .lpo_clk_i,
    .reset_pin_n_i(pin_n), .serial_prog_mode_select_n_i(1'b1),
    .boot_config_pin0_i(1'b1), .flash_option_byte_i(8'h00),
    .stop_mode_i(1'b0), .reset_irq_o, .sys_reset_o, .force_boot_rom_o);
  rcu_partner i_src (.clk_i, .srst_i, .fire_i(fire),
    .sys_reset_i(sys_reset_o), .src_req_o(src_req_i),
    .lpo_clk_o(lpo_clk_i));

  // ****************************************
  // Shared tasks
  // ****************************************
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      mismatches++;
    end
  endtask

  // Bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_awaddr_i <= a;
    s_wdata_i <= d;
    s_awvalid_i <= 1'b1;
    s_wvalid_i <= 1'b1;
    s_bready_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
      if (s_awready_o) s_awvalid_i <= 1'b0;
      if (s_wready_o) s_wvalid_i <= 1'b0;
    end
    while (!(s_bvalid_o && !s_awvalid_i && !s_wvalid_i) && n < 200);
    if (n >= 200) mismatches++;
    rd_r = s_bresp_o;
    s_bready_i <= 1'b0;
  endtask

  // Bus read into rd_d and rd_r
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    s_rready_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
      if (s_arready_o) s_arvalid_i <= 1'b0;
    end
    while (!s_rvalid_o && n < 200);
    if (n >= 200) mismatches++;
    rd_d = s_rdata_o;
    rd_r = s_rresp_o;
    s_rready_i <= 1'b0;
  endtask

  // Fire one source for a cycle; the partner holds its request
  task automatic raise(input logic [12:0] m);
    @(posedge clk_i);
    fire <= m;
    @(posedge clk_i);
    fire <= 13'h0000;
  endtask

  // Wait for the system reset pulse and measure it
  task automatic pulse();
    n = 0;
    while (!sys_reset_o && n < 200)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(reset_irq_o, 1'b0);
    n = 0;
    while (sys_reset_o && n < 40)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(n, 16);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Identity, implemented map, defaults, unmapped place
  task automatic t_regs();
    rd(8'h00); chk(rd_d, 32'h0100_0003);
    rd(8'h04); chk(rd_d, 32'h0000_1FFF);
    rd(8'h20); chk(rd_d, 32'h0);
    rd(8'h40); chk(rd_r, 2'h2);
    wr(8'h40, 32'h0); chk(rd_r, 2'h2);
    $display("test regs done");
  endtask

  // Source without an enable resets at once
  task automatic t_direct();
    raise(13'h0002);
    pulse();
    rd(8'h08); chk(rd_d, 32'h2);
    rd(8'h18); chk(rd_d, 32'h2);
    $display("test direct done");
  endtask

  // Enabled watchdog source: interrupt, then delayed reset
  task automatic t_delay();
    wr(8'h20, 32'h50);
    raise(13'h0010);
    n = 0;
    while (!reset_irq_o && n < 10)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(reset_irq_o, 1'b1);
    n = 0;
    while (reset_irq_o && n < 200)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(n >= 50 && n <= 80, 1'b1);
    pulse();
    rd(8'h08); chk(rd_d, 32'h10);
    rd(8'h0C); chk(rd_d, 32'h12);
    $display("test delay done");
  endtask

  // Selective clears and boot forcing
  task automatic t_clear();
    wr(8'h0C, 32'h10);
    rd(8'h0C); chk(rd_d, 32'h02);
    wr(8'h18, 32'h6);
    rd(8'h18); chk(rd_d, 32'h0);
    wr(8'h1C, 32'h2);
    chk(force_boot_rom_o, 1'b1);
    $display("test clear done");
  endtask

  // Reset pin through the bus clock filter of width ten
  task automatic t_pin();
    wr(8'h10, 32'h1);
    wr(8'h14, 32'hA);
    // Five clocks low is a glitch and must be dropped
    pin_n <= 1'b0;
    repeat (5) @(posedge clk_i);
    pin_n <= 1'b1;
    repeat (20) @(posedge clk_i);
    rd(8'h08); chk(rd_d, 32'h10);
    // Fourteen clocks low is taken; released before the pulse ends
    pin_n <= 1'b0;
    fork
      begin
        repeat (14) @(posedge clk_i);
        pin_n <= 1'b1;
      end
      pulse();
    join
    rd(8'h08); chk(rd_d, 32'h20);
    rd(8'h0C); chk(rd_d, 32'h22);
    $display("test pin done");
  endtask

  // ****************************************
  // Run control
  // ****************************************
  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    t_regs();
    t_direct();
    t_delay();
    t_clear();
    t_pin();
    end_sim();
  end

  // Watchdog against a hang
  initial
  begin
    #(25 * 5000);
    mismatches++;
    end_sim();
  end
endmodule
